// ### src/frpbs_pkg.sv
/*
 Shared constants for the flash rewrite-protect and boot-select block:
 register map, field positions, command codes, block geometry, path codes.
 Assumes a 32-bit AXI4-Lite register bus and a word-wide flash array port.
*/
package frpbs_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_A_OFS = 8'h00;
   localparam logic [7:0] CTRL_B_OFS = 8'h04;
   localparam logic [7:0] PMODE_OFS = 8'h08;
   localparam logic [7:0] CMD_OFS = 8'h0c;
   localparam logic [7:0] ADDR_OFS = 8'h10;
   localparam logic [7:0] DATA_OFS = 8'h14;
   localparam logic [7:0] STAT_OFS = 8'h18;

   // Field positions
   localparam int LOWEN_BIT = 2;
   localparam int GLBEN_BIT = 6;
   localparam int SUBM_BIT = 1;
   localparam int DSEN_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ERR_BIT = 1;
   localparam int ST_BOOT_BIT = 2;
   localparam int ST_PAR_BIT = 3;
   localparam int ST_SER2_BIT = 4;

   localparam logic [31:0] RESP_OK = 32'h0000_0000;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // ---------------------------------------------------------------
   // Five software commands
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      FRPBS_CMD_READ_ARRAY = 3'h0,
      FRPBS_CMD_READ_STATUS = 3'h1,
      FRPBS_CMD_CLEAR_STATUS = 3'h2,
      FRPBS_CMD_PROGRAM = 3'h3,
      FRPBS_CMD_BLOCK_ERASE = 3'h4
   } frpbs_cmd_t;

   // Rewrite path selection
   typedef enum logic [1:0] {
      FRPBS_PATH_CPU = 2'h0,
      FRPBS_PATH_SERIAL = 2'h1,
      FRPBS_PATH_PARALLEL = 2'h2
   } frpbs_path_t;

   // ---------------------------------------------------------------
   // Flash geometry: word address 14 bits, 8 blocks (0-5, A, B)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 14;
   localparam int BLK_W = 3;
   localparam int NUM_BLK = 8;
   localparam int DATA_W = 16;
   localparam logic [2:0] BLK_A = 3'h6;
   localparam logic [2:0] BLK_B = 3'h7;
   localparam logic [2:0] BLK_LOW_LAST = 3'h1;
   localparam logic [2:0] BLK_PROG_LAST = 3'h5;
   // 2-Kbyte data block = 1024 words
   localparam int DBLK_WORDS = 1024;
   localparam logic [13:0] DBLK_A_BASE = 14'h3000;
   localparam logic [13:0] DBLK_B_BASE = 14'h3400;
   localparam logic [13:0] BOOT_VECTOR = 14'h3ffe;
   localparam logic [13:0] USER_VECTOR = 14'h2ffe;
   localparam logic [13:0] PROG_BLK_WORDS = 14'h0800;

   // Array operation time, cycles
   localparam int OP_TIME_NS = 1000;
   localparam int CLK_NS = 100;
   localparam logic [3:0] OP_CYCLES = 4'(OP_TIME_NS / CLK_NS);

endpackage

// ### src/frpbs_sync.sv
/*
 Three-stage synchroniser for one pin level.
 A change counts once the second and third stages agree.
*/
`timescale 1ns/1ps
module frpbs_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_level <= 1'b0;
      end else if (i_ce) begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            o_level <= s3_q;
         end
      end
   end
endmodule

// ### src/frpbs_blkmap.sv
/*
 Address to block decode and rewrite-permission check.
 Pure combinational; the caller supplies enable bits and path.
*/
`timescale 1ns/1ps
module frpbs_blkmap (
   input wire logic [frpbs_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_glb_en,
   input wire logic i_low_en,
   input wire logic i_ds_en,
   input wire logic i_cpu_path,
   output logic [frpbs_pkg::BLK_W-1:0] o_blk,
   output logic o_allowed
);
   always_comb begin
      if (i_addr >= frpbs_pkg::DBLK_B_BASE) begin
         o_blk = frpbs_pkg::BLK_B;
      end else if (i_addr >= frpbs_pkg::DBLK_A_BASE) begin
         o_blk = frpbs_pkg::BLK_A;
      end else begin
         o_blk = 3'(i_addr / frpbs_pkg::PROG_BLK_WORDS);
      end
      if (o_blk >= frpbs_pkg::BLK_A) begin
         // Data blocks only while data space is enabled
         o_allowed = i_ds_en;
      end else if (!i_cpu_path) begin
         o_allowed = 1'b1;
      end else if (o_blk <= frpbs_pkg::BLK_LOW_LAST) begin
         o_allowed = i_glb_en & i_low_en;
      end else begin
         o_allowed = i_glb_en;
      end
   end
endmodule

// ### src/frpbs_top.sv
/*
 Flash rewrite control: CPU command path over AXI4-Lite, external
 serial/parallel programmer path, boot-mode capture, block protection.
 Assumes a 10 MHz clock, flash array outside with word program/erase
 strobes, and boot pins that are static around reset release.
*/
// Function
// - Flash changes only through commands; exactly five commands exist.
// - Global enable protects blocks 0-5; low enable also guards 0 and 1 (CPU path only; the external programmer path bypasses both).
// - Blocks 0 and 1 rewritable only with both enables set; the external programmer path needs neither.
// - Blocks 2-5 rewritable whenever global enable is set.
// - A word may be programmed once between erases of its block.
// - Boot on reset if mode-high and A-high, or mode-high, B-high, C-low.
// - Boot mode starts execution from the reserved boot area.
// - User area holds two 2-Kbyte data blocks A and B.
// - Data blocks accessible only while data-space enable is set; the external programmer path ignores it.
// - Serial path has clock-synchronous and UART variants.
// - CPU rewrite has run-from-RAM and run-from-flash sub-modes; the sub-mode bit is stored but drives no logic.
`timescale 1ns/1ps
module frpbs_top (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Boot straps
   input wire logic i_mode_select_pin,
   input wire logic i_boot_select_pin_a,
   input wire logic i_boot_select_pin_b,
   input wire logic i_boot_select_pin_c,
   input wire logic i_parallel_mode_pin,
   // External programmer request (same clock)
   input wire logic i_ext_req,
   input wire logic i_ext_erase,
   input wire logic [frpbs_pkg::ADDR_W-1:0] i_ext_addr,
   input wire logic [frpbs_pkg::DATA_W-1:0] i_ext_data,
   output logic o_ext_done,
   output logic o_ext_err,
   // AXI4-Lite
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Flash array
   output logic o_fl_prog,
   output logic o_fl_erase,
   output logic [frpbs_pkg::ADDR_W-1:0] o_fl_addr,
   output logic [frpbs_pkg::DATA_W-1:0] o_fl_wdata,
   output logic o_data_space_en,
   output logic o_boot_mode,
   output logic o_ser_uart,
   output logic [frpbs_pkg::ADDR_W-1:0] o_start_vector
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] pin_raw;
   logic [4:0] pin_lvl;
   assign pin_raw = {i_parallel_mode_pin, i_boot_select_pin_c, i_boot_select_pin_b,
                     i_boot_select_pin_a, i_mode_select_pin};
   for (genvar g = 0; g < 5; g++) begin : g_sync
      frpbs_sync u_sync (
         .i_clk(i_clk),
         .i_rst_n(i_rst_n),
         .i_ce(i_ce),
         .i_pin(pin_raw[g]),
         .o_level(pin_lvl[g])
      );
   end

   // ---------------------------------------------------------------
   // Boot capture after reset release
   // ---------------------------------------------------------------
   logic [2:0] boot_wait_q;
   logic boot_done_q;
   logic boot_q;
   logic par_q;
   logic ser_uart_q;
   logic boot_cond;
   assign boot_cond = pin_lvl[0] & (pin_lvl[1] | (pin_lvl[2] & ~pin_lvl[3]));

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         boot_wait_q <= 3'h0;
         boot_done_q <= 1'b0;
         boot_q <= 1'b0;
         par_q <= 1'b0;
         ser_uart_q <= 1'b0;
      end else if (i_ce && !boot_done_q) begin
         boot_wait_q <= boot_wait_q + 3'h1;
         if (boot_wait_q == 3'h5) begin
            boot_done_q <= 1'b1;
            boot_q <= boot_cond;
            par_q <= pin_lvl[4] & ~boot_cond;
            // UART variant when boot via pin B, else clock-synchronous
            ser_uart_q <= boot_cond & ~pin_lvl[1];
         end
      end
   end
   assign o_boot_mode = boot_q;
   assign o_ser_uart = ser_uart_q;
   // Start from boot area when booting
   assign o_start_vector = boot_q ? frpbs_pkg::BOOT_VECTOR : frpbs_pkg::USER_VECTOR;

   frpbs_pkg::frpbs_path_t path;
   always_comb begin
      if (boot_q) begin
         path = frpbs_pkg::FRPBS_PATH_SERIAL;
      end else if (par_q) begin
         path = frpbs_pkg::FRPBS_PATH_PARALLEL;
      end else begin
         path = frpbs_pkg::FRPBS_PATH_CPU;
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   logic [7:0] flash_control_reg_a_q;
   logic [7:0] flash_control_reg_b_q;
   logic [7:0] processor_mode_reg_b_q;
   logic [2:0] cmd_q;
   logic [frpbs_pkg::ADDR_W-1:0] addr_q;
   logic [frpbs_pkg::DATA_W-1:0] data_q;
   logic low_block_rewrite_enable;
   logic global_block_rewrite_enable;
   logic data_space_access_enable;
   logic rewrite_from_flash_submode;
   assign low_block_rewrite_enable = flash_control_reg_a_q[frpbs_pkg::LOWEN_BIT];
   assign global_block_rewrite_enable = flash_control_reg_b_q[frpbs_pkg::GLBEN_BIT];
   assign data_space_access_enable = processor_mode_reg_b_q[frpbs_pkg::DSEN_BIT];
   assign rewrite_from_flash_submode = flash_control_reg_b_q[frpbs_pkg::SUBM_BIT];
   assign o_data_space_en = data_space_access_enable;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   logic aw_got_q;
   logic w_got_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic wr_fire;
   logic busy_q;
   logic cmd_go;
   assign o_awready = ~aw_got_q & ~bvalid_q;
   assign o_wready = ~w_got_q & ~bvalid_q;
   assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;

   function automatic logic known_ofs(input logic [7:0] a);
      return (a <= frpbs_pkg::STAT_OFS) && (a[1:0] == 2'h0);
   endfunction

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= frpbs_pkg::AXI_OKAY;
      end else if (i_ce) begin
         if (i_awvalid && o_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= i_wdata;
            wstrb0_q <= i_wstrb[0];
         end
         if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= known_ofs(awaddr_q) ? frpbs_pkg::AXI_OKAY : frpbs_pkg::AXI_SLVERR;
         end else if (bvalid_q && i_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flash_control_reg_a_q <= 8'h00;
         flash_control_reg_b_q <= 8'h00;
         processor_mode_reg_b_q <= 8'h00;
         cmd_q <= 3'h0;
         addr_q <= '0;
         data_q <= '0;
      end else if (i_ce && wr_fire && wstrb0_q) begin
         case (awaddr_q)
            frpbs_pkg::CTRL_A_OFS: flash_control_reg_a_q <= wdata_q[7:0];
            frpbs_pkg::CTRL_B_OFS: flash_control_reg_b_q <= wdata_q[7:0];
            frpbs_pkg::PMODE_OFS: processor_mode_reg_b_q <= wdata_q[7:0];
            frpbs_pkg::CMD_OFS: cmd_q <= wdata_q[2:0];
            frpbs_pkg::ADDR_OFS: addr_q <= wdata_q[frpbs_pkg::ADDR_W-1:0];
            frpbs_pkg::DATA_OFS: data_q <= wdata_q[frpbs_pkg::DATA_W-1:0];
            default: ;
         endcase
      end
   end
   assign cmd_go = i_ce && wr_fire && (awaddr_q == frpbs_pkg::CMD_OFS) && !busy_q
                   && (path == frpbs_pkg::FRPBS_PATH_CPU);

   // ---------------------------------------------------------------
   // Operation sequencer
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {FRPBS_IDLE, FRPBS_CHECK, FRPBS_RUN, FRPBS_DONE} frpbs_st_t;
   frpbs_st_t st_q;
   logic op_erase_q;
   logic op_ext_q;
   logic [frpbs_pkg::ADDR_W-1:0] op_addr_q;
   logic [frpbs_pkg::DATA_W-1:0] op_data_q;
   logic [3:0] op_cnt_q;
   logic err_q;
   logic [frpbs_pkg::BLK_W-1:0] op_blk;
   logic op_allowed;
   logic [(1 << frpbs_pkg::ADDR_W)-1:0] written_q;
   logic [frpbs_pkg::ADDR_W-1:0] wr_idx;
   logic ext_go;
   logic op_ok;
   assign ext_go = i_ext_req && !busy_q && (path != frpbs_pkg::FRPBS_PATH_CPU);
   assign busy_q = (st_q != FRPBS_IDLE);
   assign wr_idx = op_addr_q;

   frpbs_blkmap u_map (
      .i_addr(op_addr_q),
      .i_glb_en(global_block_rewrite_enable),
      .i_low_en(low_block_rewrite_enable),
      .i_ds_en(data_space_access_enable | op_ext_q),
      .i_cpu_path(~op_ext_q),
      .o_blk(op_blk),
      .o_allowed(op_allowed)
   );
   // Protected block or repeated program refused
   assign op_ok = op_allowed && (op_erase_q || !written_q[wr_idx]);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= FRPBS_IDLE;
         op_erase_q <= 1'b0;
         op_ext_q <= 1'b0;
         op_addr_q <= '0;
         op_data_q <= '0;
         op_cnt_q <= 4'h0;
         err_q <= 1'b0;
      end else if (i_ce) begin
         case (st_q)
            FRPBS_IDLE: begin
               if (cmd_go) begin
                  err_q <= 1'b0;
                  // Only program and erase touch the array
                  if (wdata_q[2:0] == frpbs_pkg::FRPBS_CMD_PROGRAM ||
                      wdata_q[2:0] == frpbs_pkg::FRPBS_CMD_BLOCK_ERASE) begin
                     st_q <= FRPBS_CHECK;
                     op_erase_q <= (wdata_q[2:0] == frpbs_pkg::FRPBS_CMD_BLOCK_ERASE);
                     op_ext_q <= 1'b0;
                     op_addr_q <= addr_q;
                     op_data_q <= data_q;
                  end
               end else if (ext_go) begin
                  st_q <= FRPBS_CHECK;
                  op_erase_q <= i_ext_erase;
                  op_ext_q <= 1'b1;
                  op_addr_q <= i_ext_addr;
                  op_data_q <= i_ext_data;
                  err_q <= 1'b0;
               end
            end
            FRPBS_CHECK: begin
               op_cnt_q <= frpbs_pkg::OP_CYCLES;
               if (op_ok) begin
                  st_q <= FRPBS_RUN;
               end else begin
                  err_q <= 1'b1;
                  st_q <= FRPBS_DONE;
               end
            end
            FRPBS_RUN: begin
               op_cnt_q <= op_cnt_q - 4'h1;
               if (op_cnt_q == 4'h1) begin
                  st_q <= FRPBS_DONE;
               end
            end
            FRPBS_DONE: st_q <= FRPBS_IDLE;
            default: st_q <= FRPBS_IDLE;
         endcase
      end
   end

   // Block of a word address, same split as the protection map
   function automatic logic [frpbs_pkg::BLK_W-1:0] blk_of(input int a);
      if (a >= int'(frpbs_pkg::DBLK_B_BASE)) begin
         return frpbs_pkg::BLK_B;
      end else if (a >= int'(frpbs_pkg::DBLK_A_BASE)) begin
         return frpbs_pkg::BLK_A;
      end
      return 3'(a / int'(frpbs_pkg::PROG_BLK_WORDS));
   endfunction

   // Program-once tracking per word, cleared by block erase
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         written_q <= '0;
      end else if (i_ce && st_q == FRPBS_CHECK && op_ok) begin
         if (op_erase_q) begin
            for (int i = 0; i < (1 << frpbs_pkg::ADDR_W); i++) begin
               if (blk_of(i) == op_blk) begin
                  written_q[i] <= 1'b0;
               end
            end
         end else begin
            written_q[wr_idx] <= 1'b1;
         end
      end
   end

   // Array strobes held through the run phase only
   assign o_fl_prog = (st_q == FRPBS_RUN) && !op_erase_q;
   assign o_fl_erase = (st_q == FRPBS_RUN) && op_erase_q;
   assign o_fl_addr = op_addr_q;
   assign o_fl_wdata = op_data_q;
   assign o_ext_done = (st_q == FRPBS_DONE) && op_ext_q;
   assign o_ext_err = err_q;

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [31:0] stat_word;
   assign o_arready = ~rvalid_q;
   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;
   always_comb begin
      stat_word = frpbs_pkg::RESP_OK;
      stat_word[frpbs_pkg::ST_BUSY_BIT] = busy_q;
      stat_word[frpbs_pkg::ST_ERR_BIT] = err_q;
      stat_word[frpbs_pkg::ST_BOOT_BIT] = boot_q;
      stat_word[frpbs_pkg::ST_PAR_BIT] = par_q;
      stat_word[frpbs_pkg::ST_SER2_BIT] = ser_uart_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= frpbs_pkg::AXI_OKAY;
      end else if (i_ce) begin
         if (i_arvalid && o_arready) begin
            rvalid_q <= 1'b1;
            rresp_q <= known_ofs(i_araddr) ? frpbs_pkg::AXI_OKAY : frpbs_pkg::AXI_SLVERR;
            case (i_araddr)
               frpbs_pkg::CTRL_A_OFS: rdata_q <= {24'h0, flash_control_reg_a_q};
               frpbs_pkg::CTRL_B_OFS: rdata_q <= {24'h0, flash_control_reg_b_q};
               frpbs_pkg::PMODE_OFS: rdata_q <= {24'h0, processor_mode_reg_b_q};
               frpbs_pkg::CMD_OFS: rdata_q <= {29'h0, cmd_q};
               frpbs_pkg::ADDR_OFS: rdata_q <= {18'h0, addr_q};
               frpbs_pkg::DATA_OFS: rdata_q <= {16'h0, data_q};
               frpbs_pkg::STAT_OFS: rdata_q <= stat_word;
               default: rdata_q <= 32'h0000_0000;
            endcase
         end else if (rvalid_q && i_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence run_seq;
      st_q == FRPBS_CHECK ##1 st_q == FRPBS_RUN;
   endsequence

   prot_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_fl_prog || o_fl_erase) && !op_ext_q && op_blk <= frpbs_pkg::BLK_LOW_LAST
      |-> global_block_rewrite_enable && low_block_rewrite_enable)
      else $error("low block rewritten without both enables");
   prot_mid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_fl_prog || o_fl_erase) && !op_ext_q && op_blk < frpbs_pkg::BLK_A
      |-> global_block_rewrite_enable)
      else $error("program block rewritten without global enable");
   ds_gate_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (o_fl_prog || o_fl_erase) && !op_ext_q && op_blk >= frpbs_pkg::BLK_A
      |-> data_space_access_enable)
      else $error("data block touched while disabled");
   refuse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_ce && st_q == FRPBS_CHECK && !op_ok |=> st_q == FRPBS_DONE && err_q && !o_fl_prog)
      else $error("protected operation reached array");
   run_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      i_ce throughout run_seq |-> o_fl_prog || o_fl_erase)
      else $error("run phase without array strobe");
   once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      st_q == FRPBS_CHECK && !op_erase_q && written_q[wr_idx] |=> !o_fl_prog)
      else $error("word programmed twice");
   boot_vec_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      boot_q |-> o_start_vector == frpbs_pkg::BOOT_VECTOR)
      else $error("boot mode without boot vector");
   boot_cap_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      $rose(boot_done_q) |-> boot_q == $past(boot_cond))
      else $error("boot strap misread");
endmodule

// ### sim/frpbs_flash_model.sv
/*
 Behavioural flash array: remembers which words were programmed.
 Assumes program strobe high for a whole operation, same clock.
*/
`timescale 1ns/1ps
module frpbs_flash_model (
   input wire logic i_clk,
   input wire logic i_prog,
   input wire logic i_erase,
   input wire logic [13:0] i_addr,
   output logic o_dbl
);
   logic [16383:0] used_q = '0;
   logic prog_q = 1'b0;
   logic dbl_q = 1'b0;
   assign o_dbl = dbl_q;
   // ----------------------------------------
   // Word usage tracking
   // ----------------------------------------
   always @(posedge i_clk) begin
      prog_q <= i_prog;
      if (i_prog && !prog_q) begin
         if (used_q[i_addr]) dbl_q <= 1'b1;
         used_q[i_addr] <= 1'b1;
      end
      if (i_erase) begin
         for (int k = 0; k < 16384; k++) if (k[13:11] == i_addr[13:11]) used_q[k] <= 1'b0;
      end
   end
endmodule

// ### sim/flash_rewrite_protect_boot_select_bench.sv
/*
 Self-checking bench for the flash rewrite control block.
 Assumes 10 MHz clock and register map from the package.
*/
`timescale 1ns/1ps
module flash_rewrite_protect_boot_select_bench;
   logic i_clk = 0, i_rst_n = 0, m = 0, pa = 0, pb = 0, pc = 0, xreq = 0, xer = 0;
   logic [13:0] xad = '0, fa, sv;
   logic [15:0] fd;
   logic [7:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, rdat, v;
   logic [1:0] br, rr, r;
   logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, awr, wr_r, bv, arr, rv;
   logic xd, xe, fp, fe, ds, bm, su, dbl, t1, t2;
   int fails = 0, n_checks = 0, cyc = 0, n, nd;
   always #50 i_clk = ~i_clk;
   frpbs_top u_frpbs_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
      .i_mode_select_pin(m), .i_boot_select_pin_a(pa), .i_boot_select_pin_b(pb),
      .i_boot_select_pin_c(pc), .i_parallel_mode_pin(1'b0), .i_ext_req(xreq),
      .i_ext_erase(xer), .i_ext_addr(xad), .i_ext_data(16'h5a5a), .o_ext_done(xd),
      .o_ext_err(xe), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
      .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(br), .o_bvalid(bv),
      .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdat),
      .o_rresp(rr), .o_rvalid(rv), .i_rready(rre), .o_fl_prog(fp), .o_fl_erase(fe),
      .o_fl_addr(fa), .o_fl_wdata(fd), .o_data_space_en(ds), .o_boot_mode(bm),
      .o_ser_uart(su), .o_start_vector(sv));
   frpbs_flash_model u_frpbs_flash_model (.i_clk(i_clk), .i_prog(fp), .i_erase(fe),
      .i_addr(fa), .o_dbl(dbl));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge i_clk) if (++cyc == 20000) begin fails++; tally_and_finish; end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
      while (awv || wv) begin
         @(negedge i_clk); t1 = awv && awr; t2 = wv && wr_r;
         @(posedge i_clk); if (t1) awv <= 0; if (t2) wv <= 0;
      end
      do begin @(negedge i_clk); t1 = bv; r = br; @(posedge i_clk); end while (!t1);
      bre <= 0;
   endtask
   task rd(input logic [7:0] a);
      ara <= a; arv <= 1; rre <= 1;
      do begin @(negedge i_clk); t1 = arr; @(posedge i_clk); end while (!t1);
      arv <= 0;
      do begin @(negedge i_clk); t1 = rv; v = rdat; r = rr; @(posedge i_clk); end while (!t1);
      rre <= 0;
   endtask
   task strobes;
      n = 0;
      nd = 0;
      repeat (20) begin
         @(negedge i_clk);
         if (fp === 1'b1 || fe === 1'b1) n++;
         if (xd === 1'b1) nd++;
      end
      @(posedge i_clk);
   endtask
   task op(input logic [13:0] ad, input frpbs_pkg::frpbs_cmd_t c, input logic ok);
      wr(frpbs_pkg::ADDR_OFS, 32'(ad));
      wr(frpbs_pkg::DATA_OFS, 32'h0000_1234);
      wr(frpbs_pkg::CMD_OFS, 32'(c));
      strobes;
      chk(n, ok ? 32'(frpbs_pkg::OP_CYCLES) : 32'h0);
      chk(32'(fa), 32'(ad));
      chk(32'(fd), 32'h0000_1234);
   endtask
   task boot(input logic [3:0] p);
      {m, pa, pb, pc} <= p; i_rst_n <= 0;
      repeat (6) @(posedge i_clk);
      i_rst_n <= 1;
      repeat (10) @(posedge i_clk);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_protect;
      wr(frpbs_pkg::CTRL_B_OFS, 32'h0000_0042);
      chk(r, frpbs_pkg::AXI_OKAY);
      rd(frpbs_pkg::CTRL_B_OFS);
      chk(v, 32'h0000_0042);
      op(14'h0000, frpbs_pkg::FRPBS_CMD_PROGRAM, 0);
      op(14'h1000, frpbs_pkg::FRPBS_CMD_PROGRAM, 1);
      op(14'h1000, frpbs_pkg::FRPBS_CMD_PROGRAM, 0);
      op(14'h1000, frpbs_pkg::FRPBS_CMD_BLOCK_ERASE, 1);
      op(14'h1000, frpbs_pkg::FRPBS_CMD_PROGRAM, 1);
      wr(frpbs_pkg::CTRL_A_OFS, 32'h0000_0004);
      op(14'h0002, frpbs_pkg::FRPBS_CMD_PROGRAM, 1);
      op(14'h3000, frpbs_pkg::FRPBS_CMD_PROGRAM, 0);
      wr(frpbs_pkg::PMODE_OFS, 32'h0000_0001);
      chk(ds, 1);
      op(14'h33fe, frpbs_pkg::FRPBS_CMD_PROGRAM, 1);
      wr(frpbs_pkg::CTRL_B_OFS, 32'h0000_0000);
      op(14'h2800, frpbs_pkg::FRPBS_CMD_PROGRAM, 0);
      op(14'h0800, frpbs_pkg::FRPBS_CMD_BLOCK_ERASE, 0);
      rd(8'h40);
      chk(r, frpbs_pkg::AXI_SLVERR);
      chk(dbl, 0);
      $display("protection test done");
   endtask
   task t_boot;
      logic [3:0] pat [4] = '{4'b1100, 4'b1011, 4'b0100, 4'b1010};
      logic e;
      for (int i = 0; i < 4; i++) begin
         boot(pat[i]);
         e = pat[i][3] & (pat[i][2] | (pat[i][1] & ~pat[i][0]));
         chk(bm, e);
         chk(sv, e ? frpbs_pkg::BOOT_VECTOR : frpbs_pkg::USER_VECTOR);
         chk(su, e & ~pat[i][2]);
         rd(frpbs_pkg::STAT_OFS);
         chk(v[frpbs_pkg::ST_BOOT_BIT], e);
      end
      // User area only, never the boot area
      xad <= 14'h0100; xreq <= 1;
      @(posedge i_clk);
      xreq <= 0;
      strobes;
      chk(n, 32'(frpbs_pkg::OP_CYCLES));
      chk(xe, 0);
      chk(nd, 1);
      $display("boot test done");
   endtask
   initial begin
      boot(4'b0000);
      t_protect;
      t_boot;
      tally_and_finish;
   end
endmodule
